// [rtl/pic_top.sv]
`include "pic_consts.svh"
`default_nettype none
module pic_top #(
  // Latch index runs to the last timer; swi/undef share 0, slots 1 and 2 unused
  parameter int NSRC = `PIC_NUM_SRC + 1,
  parameter int NEST_DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [NSRC-1:0] src_req_in,
  input wire logic swi_in,
  input wire logic undef_in,
  input wire logic ack_in,
  input wire logic return_from_irq_op_in,
  output logic irq_valid_out,
  output logic [15:0] vector_out,
  output logic [4:0] irq_src_out,
  output logic reset_vector_out,
  output logic vector_ram_select_out,
  output logic irq_out
);
  localparam int LW = `PIC_LVL_W;
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [NSRC-1:0] pending_latch_q, pending_latch_d;
  logic [NSRC-1:0] source_enable_q, source_enable_d;
  logic master_enable_q, master_enable_d;
  logic vector_relocate_q, vector_relocate_d;
  logic vector_ram_select_q, vector_ram_select_d;
  logic [NSRC*LW-1:0] priority_level_regs_q, priority_level_regs_d;
  logic [NEST_DEPTH-1:0] stack_q, stack_d;
  logic [3:0] depth_q, depth_d;
  logic swi_q, swi_d, undef_q, undef_d;
  pic_pkg::pic_state_t state_q, state_d;
  pic_pkg::pic_req_t offer_q, offer_d;
  logic [2:0] irq_stat_q, irq_stat_d;
  logic [2:0] irq_en_q, irq_en_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic [NSRC-1:0] eligible;
  logic found;
  logic [4:0] win_src;
  logic [15:0] win_vec;
  logic nmi_any, sel_swi;
  always_comb begin
    eligible = '0;
    for (int i = `PIC_FIRST_MASK; i < NSRC; i++) begin
      eligible[i] = pending_latch_q[i] && source_enable_q[i] && master_enable_q;
    end
  end
  assign nmi_any = swi_q || undef_q || pending_latch_q[`PIC_WDT_BIT];
  // Fixed order among nmis: swi, then undef, then wdt
  assign sel_swi = swi_q || undef_q;
  pic_arbiter #(.NSRC(NSRC)) u_arb (
    .req_in(eligible),
    .lvl_in(priority_level_regs_q),
    .found_out(found),
    .src_out(win_src)
  );
  pic_vector_map u_vec (
    .src_in(nmi_any ? 5'(`PIC_WDT_BIT) : win_src),
    .nmi_swi_in(nmi_any && sel_swi),
    .reloc_in(vector_relocate_q),
    .vector_out(win_vec)
  );
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  logic wr, rd;
  logic [3:0] lvl_idx;
  assign wr = psel_in && penable_in && pwrite_in;
  assign rd = psel_in && !penable_in && !pwrite_in;
  assign lvl_idx = 4'(paddr_in[5:2] - 4'h3);
  always_comb begin
    pending_latch_d = pending_latch_q;
    source_enable_d = source_enable_q;
    master_enable_d = master_enable_q;
    vector_relocate_d = vector_relocate_q;
    vector_ram_select_d = vector_ram_select_q;
    priority_level_regs_d = priority_level_regs_q;
    stack_d = stack_q;
    depth_d = depth_q;
    state_d = state_q;
    offer_d = offer_q;
    irq_stat_d = irq_stat_q;
    irq_en_d = irq_en_q;
    prdata_d = prdata_q;
    pready_d = psel_in && !penable_in;
    pslverr_d = 1'b0;
    swi_d = swi_q || swi_in;
    undef_d = undef_q || undef_in;
    if (wr) begin
      unique case (paddr_in)
        `PIC_OFF_PEND: pending_latch_d = pending_latch_q & pwdata_in[NSRC-1:0];
        `PIC_OFF_ENABLE: source_enable_d = pwdata_in[NSRC-1:0];
        `PIC_OFF_CTRL: begin
          master_enable_d = pwdata_in[`PIC_CTRL_MASTER];
          vector_relocate_d = pwdata_in[`PIC_CTRL_RELOC];
          vector_ram_select_d = pwdata_in[`PIC_CTRL_RAMSEL];
        end
        `PIC_OFF_IRQ_EN: irq_en_d = pwdata_in[2:0];
        `PIC_OFF_IRQ_CLR: irq_stat_d = irq_stat_q & ~pwdata_in[2:0];
        default: begin
          if (paddr_in >= `PIC_OFF_LVL0 && paddr_in < `PIC_OFF_IRQ_STAT) begin
            for (int k = 0; k < 4; k++) begin
              if (int'(lvl_idx) * 4 + k < NSRC) begin
                priority_level_regs_d[(int'(lvl_idx) * 4 + k)*LW +: LW] =
                  pwdata_in[k*8 +: LW];
              end
            end
          end
        end
      endcase
    end
    // Flag decided at setup so it stands with pready
    if (psel_in && !penable_in && !(paddr_in <= `PIC_OFF_STATUS && paddr_in[1:0] == 2'b00))
      pslverr_d = 1'b1;
    if (rd) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr_in)
        `PIC_OFF_PEND: prdata_d[NSRC-1:0] = pending_latch_q;
        `PIC_OFF_ENABLE: prdata_d[NSRC-1:0] = source_enable_q;
        `PIC_OFF_CTRL: prdata_d[2:0] = {vector_ram_select_q, vector_relocate_q, master_enable_q};
        `PIC_OFF_IRQ_STAT: prdata_d[2:0] = irq_stat_q;
        `PIC_OFF_IRQ_EN: prdata_d[2:0] = irq_en_q;
        `PIC_OFF_STATUS: prdata_d = {20'h00000, depth_q, 1'b0, offer_q.src, state_q};
        default: begin
          if (paddr_in >= `PIC_OFF_LVL0 && paddr_in < `PIC_OFF_IRQ_STAT) begin
            for (int k = 0; k < 4; k++) begin
              if (int'(lvl_idx) * 4 + k < NSRC) begin
                prdata_d[k*8 +: LW] = priority_level_regs_q[(int'(lvl_idx) * 4 + k)*LW +: LW];
              end
            end
          end
        end
      endcase
    end
    if (return_from_irq_op_in && depth_q != 4'h0) begin
      master_enable_d = stack_q[0];
      stack_d = {1'b0, stack_q[NEST_DEPTH-1:1]};
      depth_d = 4'(depth_q - 4'h1);
      irq_stat_d[1] = 1'b1;
    end
    // ----------------------------------------
    // Offer and acceptance
    // ----------------------------------------
    unique case (state_q)
      pic_pkg::PIC_IDLE: begin
        // One at a time, re-evaluated each cycle
        if (nmi_any || found) begin
          offer_d.valid = 1'b1;
          offer_d.nmi = nmi_any;
          offer_d.src = nmi_any ? (sel_swi ? 5'h00 : 5'(`PIC_WDT_BIT)) : win_src;
          offer_d.vector = win_vec;
          state_d = pic_pkg::PIC_OFFER;
        end
      end
      pic_pkg::PIC_OFFER: begin
        if (ack_in) begin
          offer_d.valid = 1'b0;
          offer_d.vector = `PIC_VEC_RESET;
          if (offer_d.src >= 5'(`PIC_WDT_BIT)) pending_latch_d[offer_d.src] = 1'b0;
          else if (swi_q) swi_d = swi_in;
          else undef_d = undef_in;
          // Stack and clear master enable; nesting
          stack_d = {stack_q[NEST_DEPTH-2:0], master_enable_d};
          master_enable_d = 1'b0;
          if (depth_q < 4'(NEST_DEPTH)) depth_d = 4'(depth_d + 4'h1);
          else irq_stat_d[2] = 1'b1;
          irq_stat_d[0] = 1'b1;
          state_d = pic_pkg::PIC_WAIT_DONE;
        end
      end
      pic_pkg::PIC_WAIT_DONE: state_d = pic_pkg::PIC_IDLE;
      default: state_d = pic_pkg::PIC_IDLE;
    endcase
    // Requests set latches; set beats clear
    pending_latch_d = pending_latch_d | (src_req_in & {{(NSRC-3){1'b1}}, 3'b000});
    irq_d = |(irq_stat_d & irq_en_d);
  end
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_latch_q <= '0;
      source_enable_q <= '0;
      master_enable_q <= 1'b0;
      vector_relocate_q <= 1'b0;
      vector_ram_select_q <= 1'b0;
      priority_level_regs_q <= '0;
      stack_q <= '0;
      depth_q <= 4'h0;
      swi_q <= 1'b0;
      undef_q <= 1'b0;
      state_q <= pic_pkg::PIC_IDLE;
      offer_q <= '{valid: 1'b0, nmi: 1'b0, src: 5'h00, vector: `PIC_VEC_RESET};
      irq_stat_q <= 3'h0;
      irq_en_q <= 3'h0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pending_latch_q <= pending_latch_d;
      source_enable_q <= source_enable_d;
      master_enable_q <= master_enable_d;
      vector_relocate_q <= vector_relocate_d;
      vector_ram_select_q <= vector_ram_select_d;
      priority_level_regs_q <= priority_level_regs_d;
      stack_q <= stack_d;
      depth_q <= depth_d;
      swi_q <= swi_d;
      undef_q <= undef_d;
      state_q <= state_d;
      offer_q <= offer_d;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end
  // Reset vector fixed; flag for core
  assign reset_vector_out = 1'b0;
  assign irq_valid_out = offer_q.valid;
  assign vector_out = offer_q.vector;
  assign irq_src_out = offer_q.src;
  assign vector_ram_select_out = vector_ram_select_q;
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign irq_out = irq_q;
endmodule // pic_top
`default_nettype wire

// [rtl/pic_consts.svh]
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PIC_OFF_PEND 12'h000
`define PIC_OFF_ENABLE 12'h004
`define PIC_OFF_CTRL 12'h008
`define PIC_OFF_LVL0 12'h00c
`define PIC_OFF_IRQ_STAT 12'h024
`define PIC_OFF_IRQ_EN 12'h028
`define PIC_OFF_IRQ_CLR 12'h02c
`define PIC_OFF_STATUS 12'h030
// ----------------------------------------
// Control fields
// ----------------------------------------
`define PIC_CTRL_MASTER 0
`define PIC_CTRL_RELOC 1
`define PIC_CTRL_RAMSEL 2
// ----------------------------------------
// Vectors and sizes
// ----------------------------------------
`define PIC_NUM_SRC 25
`define PIC_FIRST_MASK 4
`define PIC_WDT_BIT 3
`define PIC_VEC_RESET 16'hfffe
`define PIC_VEC_SWI_HI 16'hfffc
`define PIC_VEC_SWI_LO 16'h01fc
`define PIC_VEC_WDT_HI 16'hfff8
`define PIC_VEC_WDT_LO 16'h01f8
`define PIC_LVL_W 4
`endif

// [rtl/pic_pkg.sv]
`default_nettype none
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_OFFER = 2'b01,
    PIC_WAIT_DONE = 2'b11
  } pic_state_t;
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [4:0] src;
    logic [15:0] vector;
  } pic_req_t;
endpackage
`default_nettype wire

// [rtl/pic_vector_map.sv]
`include "pic_consts.svh"
`default_nettype none
// Maps a source index to its vector; both areas descend by two per source
module pic_vector_map (
  input wire logic [4:0] src_in,
  input wire logic nmi_swi_in,
  input wire logic reloc_in,
  output logic [15:0] vector_out
);
  logic [15:0] base;
  always_comb begin
    base = reloc_in ? `PIC_VEC_WDT_LO : `PIC_VEC_WDT_HI;
    if (nmi_swi_in) begin
      vector_out = reloc_in ? `PIC_VEC_SWI_LO : `PIC_VEC_SWI_HI;
    end else begin
      vector_out = base - {10'h000, (src_in - 5'h03), 1'b0};
    end
  end
endmodule // pic_vector_map
`default_nettype wire

// [rtl/pic_arbiter.sv]
`include "pic_consts.svh"
`default_nettype none
// Picks the highest level, then the highest fixed priority (lowest index)
module pic_arbiter #(
  parameter int NSRC = 25
) (
  input wire logic [NSRC-1:0] req_in,
  input wire logic [NSRC*`PIC_LVL_W-1:0] lvl_in,
  output logic found_out,
  output logic [4:0] src_out
);
  logic [`PIC_LVL_W-1:0] best_lvl;
  always_comb begin
    found_out = 1'b0;
    src_out = 5'h00;
    best_lvl = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req_in[i] && (!found_out || lvl_in[i*`PIC_LVL_W +: `PIC_LVL_W] > best_lvl)) begin
        found_out = 1'b1;
        src_out = 5'(i);
        best_lvl = lvl_in[i*`PIC_LVL_W +: `PIC_LVL_W];
      end
    end
  end
endmodule // pic_arbiter
`default_nettype wire

// [verification/pic_top_props.sv]
`default_nettype none
// ------------------------------
// Offer and bus checks
// ------------------------------
module pic_top_props (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic ack_in,
  input wire logic irq_valid_out,
  input wire logic [15:0] vector_out,
  input wire logic [4:0] irq_src_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_vector_held: assert property (
    irq_valid_out && !ack_in |=> irq_valid_out && $stable(vector_out))
    else $error("offered vector moved before acceptance");
  a_src_held: assert property (
    irq_valid_out && !ack_in |=> $stable(irq_src_out))
    else $error("offered source moved before acceptance");
  a_idle_vector: assert property (!irq_valid_out |-> vector_out == 16'hfffe)
    else $error("idle vector is not the reset vector");
  a_ack_ends_offer: assert property (irq_valid_out && ack_in |=> !irq_valid_out)
    else $error("offer still standing after acceptance");
  a_mask_vector: assert property (
    irq_valid_out && irq_src_out >= 5'h03 |-> vector_out[15:8] inside {8'hff, 8'h01}
    && vector_out[7:0] == 8'hfe - {irq_src_out, 1'b0})
    else $error("source vector not two per step");
  a_shared_vector: assert property (
    irq_valid_out && irq_src_out == 5'h00 |-> vector_out[7:0] == 8'hfc)
    else $error("shared non-maskable vector wrong");
  a_src_range: assert property (
    irq_valid_out |-> irq_src_out <= 5'h19 && !(irq_src_out inside {5'h01, 5'h02}))
    else $error("offered source out of range");
  a_ready_access: assert property (psel_in && !penable_in |=> pready_out)
    else $error("access phase not answered at once");
  a_err_ready: assert property (pslverr_out |-> pready_out && psel_in && penable_in)
    else $error("error flag outside access completion");
endmodule // pic_top_props
bind pic_top pic_top_props chk_u (.clock_in, .resetn_in, .psel_in, .penable_in,
  .pready_out, .pslverr_out, .ack_in, .irq_valid_out, .vector_out, .irq_src_out);
`default_nettype wire

// [verification/pic_core_model.sv]
`default_nettype none
// ------------------------------
// Core side: accept and return
// ------------------------------
module pic_core_model (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic irq_valid_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic return_from_irq_op_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  int ret_q;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_out <= 1'b0;
      return_from_irq_op_out <= 1'b0;
      wait_q <= 0;
      ret_q <= 0;
    end else begin
      ack_out <= 1'b0;
      return_from_irq_op_out <= 1'b0;
      if (irq_valid_in && !ack_out) begin
        wait_q <= wait_q + 1;
        if (wait_q >= (slow_in ? 4 : 1)) begin
          ack_out <= 1'b1;
          wait_q <= 0;
          ret_q <= 24;
        end
      end
      if (ret_q > 0) begin
        ret_q <= ret_q - 1;
      end
      if (ret_q == 1) begin
        return_from_irq_op_out <= 1'b1;
      end
    end
  end
endmodule // pic_core_model
`default_nettype wire

// [verification/pic_top_tb.sv]
`include "pic_consts.svh"
`default_nettype none
// ------------------------------
// Bench
// ------------------------------
module pic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic swi = 1'b0, undef = 1'b0, slow = 1'b0, pready, perr, ack, return_from_irq_op, valid, irq;
  logic rvec, rsel;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [25:0] req = 26'h0;
  logic [15:0] vec;
  logic [32:0] rdq[$];
  logic [15:0] vq[$];
  int miscompares = 0, comparisons = 0, seed = 63282, s;
  pic_top dut_u (.clock_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .src_req_in(req), .swi_in(swi),
    .undef_in(undef), .ack_in(ack), .return_from_irq_op_in(return_from_irq_op), .irq_valid_out(valid),
    .vector_out(vec), .irq_src_out(), .reset_vector_out(rvec), .vector_ram_select_out(rsel),
    .irq_out(irq));
  pic_core_model core_u (.clock_in(clk), .resetn_in(rstn), .irq_valid_in(valid),
    .slow_in(slow), .ack_out(ack), .return_from_irq_op_out(return_from_irq_op));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [25:0] r, input logic sw, input logic ud);
    req <= r;
    swi <= sw;
    undef <= ud;
    @(posedge clk);
    req <= 26'h0;
    swi <= 1'b0;
    undef <= 1'b0;
    @(posedge clk);
  endtask
  // Results land at negedge, well clear of the launching edge
  always @(negedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) begin
      chk("read", rdq[0], {perr, rdq[0][32] ? 32'h0 : prdata});
      void'(rdq.pop_front());
    end
    if (valid === 1'b1 && ack === 1'b1) begin
      chk("vector", {17'h0, vq[0]}, {17'h0, vec});
      void'(vq.pop_front());
    end
  end
  initial begin
    #100us;
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`PIC_OFF_PEND, 33'h0);
    rd(`PIC_OFF_CTRL, 33'h0);
    rd(12'h100, 33'h100000000);
    chk("reset vector flag", 33'h0, {32'h0, rvec});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      s = 4 + {$random(seed)} % 22;
      slow <= i[0];
      pulse(26'h1 << s, 1'b0, 1'b0);
      rd(`PIC_OFF_PEND, 33'h1 << s);
      chk("idle", 33'h0, {32'h0, valid});
      apb(1'b1, `PIC_OFF_ENABLE, 32'h1 << s);
      chk("idle", 33'h0, {32'h0, valid});
      vq.push_back((i[0] ? 16'h01fe : 16'hfffe) - 16'(2 * s));
      apb(1'b1, `PIC_OFF_CTRL, {29'h0, i[0], i[0], 1'b1});
      chk("ram select", {32'h0, i[0]}, {32'h0, rsel});
      for (int n = 0; n < 200 && !(valid && ack); n++) @(negedge clk);
      @(posedge clk);
      rd(`PIC_OFF_CTRL, {30'h0, i[0], i[0], 1'b0});
      rd(`PIC_OFF_PEND, 33'h0);
      repeat (30) @(posedge clk);
      rd(`PIC_OFF_CTRL, {30'h0, i[0], i[0], 1'b1});
      apb(1'b1, `PIC_OFF_CTRL, 32'h0);
    end
    $display("test masking done");
    apb(1'b1, `PIC_OFF_ENABLE, 32'h220);
    for (int k = 0; k < 2; k++) begin
      vq.push_back(k ? 16'hffec : 16'hfff4);
      vq.push_back(k ? 16'hfff4 : 16'hffec);
      apb(1'b1, `PIC_OFF_LVL0 + 12'h008, k ? 32'h300 : 32'h0);
      pulse(26'h220, 1'b0, 1'b0);
      apb(1'b1, `PIC_OFF_CTRL, 32'h1);
      repeat (80) @(posedge clk);
    end
    $display("test priority done");
    apb(1'b1, `PIC_OFF_CTRL, 32'h0);
    vq.push_back(16'hfffc);
    vq.push_back(16'hfff8);
    vq.push_back(16'hfffc);
    pulse(26'h8, 1'b1, 1'b0);
    repeat (60) @(posedge clk);
    pulse(26'h0, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    $display("test non-maskable done");
    pulse(26'hc0, 1'b0, 1'b0);
    apb(1'b1, `PIC_OFF_PEND, 32'h40);
    rd(`PIC_OFF_PEND, 33'h40);
    apb(1'b1, `PIC_OFF_PEND, 32'h0);
    apb(1'b1, `PIC_OFF_PEND, 32'hffffffff);
    rd(`PIC_OFF_PEND, 33'h0);
    $display("test pending write done");
    rd(`PIC_OFF_IRQ_STAT, 33'h3);
    chk("irq", 33'h0, {32'h0, irq});
    apb(1'b1, `PIC_OFF_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 33'h1, {32'h0, irq});
    apb(1'b1, `PIC_OFF_IRQ_CLR, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq", 33'h0, {32'h0, irq});
    rd(`PIC_OFF_IRQ_STAT, 33'h0);
    $display("test interrupt done");
    // Any note left over means an offer or a read never came
    chk("queues empty", 33'h0, 33'(vq.size() + rdq.size()));
    results();
  end
endmodule // pic_top_tb
`default_nettype wire
